// file: ssp_pkg.sv
// shared constants and types for the selector scratch pad block
package ssp_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_CHAN  = 6;
  localparam int unsigned NUM_WORDS = 24;
  localparam logic [1:0] WI_CAR     = 2'h0;
  localparam logic [1:0] WI_CMD1    = 2'h1;
  localparam logic [1:0] WI_CMD2    = 2'h2;
  localparam logic [1:0] WI_ASM     = 2'h3;

  // ==========================================================
  // apb map (byte addresses, last pad word as word index)
  localparam logic [11:0] ADDR_CTRL = 12'h080;
  localparam logic [11:0] ADDR_STAT = 12'h084;
  localparam logic [4:0]  PAD_LAST  = 5'h17;

  // ==========================================================
  // control register fields
  localparam int unsigned CTL_CHAN   = 0;
  localparam int unsigned CTL_OP     = 3;
  localparam int unsigned CTL_REV    = 6;
  localparam int unsigned CTL_WR     = 7;
  localparam int unsigned CTL_DCHAIN = 8;
  localparam int unsigned CTL_MODE   = 9;
  localparam int unsigned CTL_BSEL   = 10;
  localparam int unsigned CTL_DBYTE  = 12;
  localparam int unsigned CTL_START  = 31;

  // status register fields
  localparam int unsigned STA_BUSY   = 0;
  localparam int unsigned STA_LEVEL  = 1;
  localparam int unsigned STA_SPADDR = 7;
  localparam int unsigned STA_CMD    = 14;

  // ==========================================================
  // service operations
  localparam logic [2:0] OP_FULL    = 3'h0;
  localparam logic [2:0] OP_PART    = 3'h1;
  localparam logic [2:0] OP_SCRATCH = 3'h2;
  localparam logic [2:0] OP_CHAIN   = 3'h3;
  localparam logic [2:0] OP_CHAIN4  = 3'h4;

  // address steps in bytes
  localparam logic [23:0] STEP_FULL   = 24'h000004;
  localparam logic [23:0] STEP_BYTE   = 24'h000001;
  localparam logic [23:0] STEP_CHAIN  = 24'h000008;
  localparam logic [23:0] STEP_CHAIN4 = 24'h000010;
  localparam logic [15:0] PART_LIMIT  = 16'h0004;

  // ==========================================================
  // scratch pad address pieces
  localparam logic [2:0] SEL_CAR  = 3'h2;
  localparam logic [2:0] SEL_CMD1 = 3'h4;
  localparam logic [2:0] SEL_CMD2 = 3'h3;
  localparam logic [2:0] SEL_ASM  = 3'h5;
  localparam logic [5:0][3:0] CHAN_CODE = {4'hF, 4'hB, 4'hA, 4'h7, 4'h6, 4'h3};

  // ==========================================================
  // status level display codes
  localparam logic [5:0] LVL_MM_WRITE   = 6'h38;
  localparam logic [5:0] LVL_TIC_1      = 6'h39;
  localparam logic [5:0] LVL_STORE_STAT = 6'h3A;
  localparam logic [5:0] LVL_CAR_ADV_1  = 6'h3B;
  localparam logic [5:0] LVL_CAR_ADV_2  = 6'h3C;
  localparam logic [5:0] LVL_MM_READ    = 6'h1C;
  localparam logic [5:0] LVL_CNT_1      = 6'h10;
  localparam logic [5:0] LVL_CNT_2      = 6'h11;
  localparam logic [5:0] LVL_CNT_3      = 6'h12;
  localparam logic [5:0] LVL_MMA_1      = 6'h30;
  localparam logic [5:0] LVL_MMA_2      = 6'h31;
  localparam logic [5:0] LVL_PART_IN    = 6'h08;
  localparam logic [5:0] LVL_PART_OUT   = 6'h09;
  localparam logic [5:0] LVL_SP_READ    = 6'h0C;
  localparam logic [5:0] LVL_SP_WRITE   = 6'h0D;
  localparam logic [5:0] LVL_TERM_1     = 6'h0E;
  localparam logic [5:0] LVL_MR_TO_MM   = 6'h0F;
  localparam logic [5:0] LVL_NONE       = 6'h00;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_first = 4'h2,
    st_mem   = 4'h4,
    st_done  = 4'h8
  } ssp_fsm_t;

endpackage

// file: ssp_addr_gen.sv
// scratch pad address former and first status level chooser
`timescale 1ns/100ps
`default_nettype none

module ssp_addr_gen (
  input  wire logic [2:0] chan_i,
  input  wire logic [1:0] word_i,
  input  wire logic       mode_i,
  input  wire logic       wr_i,
  input  wire logic       part_i,
  input  wire logic       rev_i,
  input  wire logic [1:0] bsel_i,
  output logic      [6:0] spaddr_o,
  output logic      [5:0] first_level_o
);

  logic [2:0] register_select_lines;
  logic [3:0] ident;
  logic [2:0] channel_identity_lines;

  // ==========================================================
  // low bits: same register code for every channel
  always_comb begin
    case (word_i)
      ssp_pkg::WI_CAR:  register_select_lines = ssp_pkg::SEL_CAR;
      ssp_pkg::WI_CMD1: register_select_lines = ssp_pkg::SEL_CMD1;
      ssp_pkg::WI_CMD2: register_select_lines = ssp_pkg::SEL_CMD2;
      default:          register_select_lines = ssp_pkg::SEL_ASM;
    endcase
  end

  // ==========================================================
  // high bits: channel identity, bit 4 common to all channels
  always_comb begin
    ident = (chan_i < 3'h6) ? ssp_pkg::CHAN_CODE[chan_i] : 4'h0;
    channel_identity_lines = {ident[3], ident[2], ident[0]} & {3{mode_i}};
  end

  assign spaddr_o = {channel_identity_lines[2:1], mode_i,
                     channel_identity_lines[0], register_select_lines};

  // ==========================================================
  // first servicing level from direction, size, order, byte select
  always_comb begin
    if (!part_i && !wr_i) begin
      first_level_o = ssp_pkg::LVL_CNT_1;
    end else if (!part_i) begin
      first_level_o = ssp_pkg::LVL_MMA_1;
    end else if (!rev_i) begin
      first_level_o = ssp_pkg::LVL_CNT_3;
    end else if (bsel_i == 2'h0) begin
      first_level_o = ssp_pkg::LVL_MMA_2;
    end else begin
      first_level_o = ssp_pkg::LVL_CNT_2;
    end
  end

endmodule

`default_nettype wire

// file: ssp_scratch_pad.sv
// selector scratch pad word set, update sequencer and apb slave
// Operation
// - six channels, four 32-bit words each
// - fourth word: data bytes, device byte top
// - command code ignored after data chaining
// - command two: flags, zeros, status, count
// - six-bit level codes, 111 and 1100 groups
// - count levels 010000-010010, memory read 011100
// - partial levels 001000 in, 001001 out
// - scratch read/write, terminate, register to memory
// - low address bits select register per channel
// - high address bits give channel code
// - words loaded at start, updated per byte
// - full word cycle moves address by four
// - partial cycle moves address by one
// - byte count minus one every byte
// - chaining advances address word two/four words
// - three select lines form low address bits
// - identity lines drive bits 3,5,6 in mode
// - address bit 4 set throughout selector mode
// - issue memory write-back and register load
// - first level chosen, later levels preselected
`timescale 1ns/100ps
`default_nettype none

module ssp_scratch_pad (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic       [6:0] scratch_addr_o,
  output logic       [5:0] status_level_o,
  output logic       [7:0] command_code_o,
  output logic             selector_mode_level_o,
  output logic             memory_register_load_command_o,
  output logic             memory_writeback_command_o
);

  typedef struct packed {
    logic [23:0][31:0] pad;
    ssp_pkg::ssp_fsm_t state;
    logic [2:0]        chan;
    logic [2:0]        op;
    logic              rev;
    logic              wr;
    logic              dchain;
    logic              mode;
    logic [1:0]        bsel;
    logic [7:0]        dbyte;
    logic [5:0]        level;
    logic [6:0]        spaddr;
    logic [7:0]        cmd;
    logic              load;
    logic              wback;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
  } ssp_state_t;

  ssp_state_t q;
  ssp_state_t n;

  logic [4:0]  base;
  logic [4:0]  i_car;
  logic [4:0]  i_cmd1;
  logic [4:0]  i_cmd2;
  logic [4:0]  i_asm;
  logic        part;
  logic        byte_op;
  logic        chain_op;
  logic [1:0]  word_sel;
  logic [6:0]  next_spaddr;
  logic [5:0]  first_level;
  logic        acc;
  logic [4:0]  pidx;
  logic        pad_hit;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [15:0] cur_cnt;
  logic [23:0] cur_car;

  // ==========================================================
  // channel word indices
  always_comb begin
    base     = {q.chan, 2'b00};
    i_car    = base | {3'h0, ssp_pkg::WI_CAR};
    i_cmd1   = base | {3'h0, ssp_pkg::WI_CMD1};
    i_cmd2   = base | {3'h0, ssp_pkg::WI_CMD2};
    i_asm    = base | {3'h0, ssp_pkg::WI_ASM};
    cur_cnt  = q.pad[i_cmd2][31:16];
    cur_car  = q.pad[i_car][31:8];
    // taken from the channel being started, not the one last serviced
    part     = q.pad[{n.chan, ssp_pkg::WI_CMD2}][31:16] < ssp_pkg::PART_LIMIT;
    byte_op  = (q.op == ssp_pkg::OP_FULL) || (q.op == ssp_pkg::OP_PART)
               || (q.op == ssp_pkg::OP_SCRATCH);
    chain_op = (q.op == ssp_pkg::OP_CHAIN) || (q.op == ssp_pkg::OP_CHAIN4);
  end

  ssp_addr_gen u_addr (
    .chan_i        (n.chan),
    .word_i        (word_sel),
    .mode_i        (n.mode),
    .wr_i          (n.wr),
    .part_i        (part),
    .rev_i         (n.rev),
    .bsel_i        (n.bsel),
    .spaddr_o      (next_spaddr),
    .first_level_o (first_level)
  );

  // ==========================================================
  // apb decode
  always_comb begin
    acc     = psel_i && penable_i && q.pready;
    pidx    = paddr_i[6:2];
    pad_hit = (paddr_i[11:7] == 5'h00) && (pidx <= ssp_pkg::PAD_LAST);
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[ssp_pkg::CTL_CHAN +: 3]  = q.chan;
    ctrl_rd[ssp_pkg::CTL_OP +: 3]    = q.op;
    ctrl_rd[ssp_pkg::CTL_REV]        = q.rev;
    ctrl_rd[ssp_pkg::CTL_WR]         = q.wr;
    ctrl_rd[ssp_pkg::CTL_DCHAIN]     = q.dchain;
    ctrl_rd[ssp_pkg::CTL_MODE]       = q.mode;
    ctrl_rd[ssp_pkg::CTL_BSEL +: 2]  = q.bsel;
    ctrl_rd[ssp_pkg::CTL_DBYTE +: 8] = q.dbyte;
    stat_rd = 32'h0000_0000;
    stat_rd[ssp_pkg::STA_BUSY]        = (q.state != ssp_pkg::st_idle);
    stat_rd[ssp_pkg::STA_LEVEL +: 6]  = q.level;
    stat_rd[ssp_pkg::STA_SPADDR +: 7] = q.spaddr;
    stat_rd[ssp_pkg::STA_CMD +: 8]    = q.cmd;
  end

  // ==========================================================
  // next state
  always_comb begin
    n         = q;
    n.load    = 1'b0;
    n.wback   = 1'b0;
    n.pslverr = 1'b0;
    // one wait state keeps pready registered
    n.pready  = psel_i && penable_i && !q.pready;
    word_sel  = ssp_pkg::WI_CMD2;

    // bus side: pad loads are initiation, refused while servicing
    if (psel_i && penable_i && !q.pready) begin
      if (pad_hit) begin
        n.prdata  = q.pad[pidx];
        n.pslverr = pwrite_i && (q.state != ssp_pkg::st_idle);
      end else if (paddr_i == ssp_pkg::ADDR_CTRL) begin
        n.prdata = ctrl_rd;
      end else if (paddr_i == ssp_pkg::ADDR_STAT) begin
        n.prdata  = stat_rd;
        n.pslverr = pwrite_i;
      end else begin
        n.prdata  = 32'h0000_0000;
        n.pslverr = 1'b1;
      end
    end
    if (acc && pwrite_i && !q.pslverr && pad_hit) begin
      n.pad[pidx] = pwdata_i;
    end
    if (acc && pwrite_i && (paddr_i == ssp_pkg::ADDR_CTRL)) begin
      n.mode = pwdata_i[ssp_pkg::CTL_MODE];
      if (q.state == ssp_pkg::st_idle) begin
        n.chan   = pwdata_i[ssp_pkg::CTL_CHAN +: 3];
        n.op     = pwdata_i[ssp_pkg::CTL_OP +: 3];
        n.rev    = pwdata_i[ssp_pkg::CTL_REV];
        n.wr     = pwdata_i[ssp_pkg::CTL_WR];
        n.dchain = pwdata_i[ssp_pkg::CTL_DCHAIN];
        n.bsel   = pwdata_i[ssp_pkg::CTL_BSEL +: 2];
        n.dbyte  = pwdata_i[ssp_pkg::CTL_DBYTE +: 8];
        // a start on a channel that does not exist is dropped
        if (pwdata_i[ssp_pkg::CTL_START] && (pwdata_i[ssp_pkg::CTL_CHAN +: 3] < 3'h6)
            && pwdata_i[ssp_pkg::CTL_MODE]) begin
          n.state = ssp_pkg::st_first;
        end
      end
    end

    // service sequencer
    case (q.state)
      ssp_pkg::st_idle: begin
        n.level = ssp_pkg::LVL_NONE;
      end
      ssp_pkg::st_first: begin
        if (!q.dchain) begin
          n.cmd = q.pad[i_cmd1][7:0];
        end
        if (byte_op) begin
          n.pad[i_cmd2][31:16] = cur_cnt - 16'h0001;
          n.pad[i_asm][{q.bsel, 3'b000} +: 8] = q.dbyte;
          if (q.op == ssp_pkg::OP_FULL) begin
            // data address field above the command code
            n.pad[i_cmd1][31:8] = q.rev ? q.pad[i_cmd1][31:8] - ssp_pkg::STEP_FULL
                                        : q.pad[i_cmd1][31:8] + ssp_pkg::STEP_FULL;
          end else if (q.op == ssp_pkg::OP_PART) begin
            n.pad[i_cmd1][31:8] = q.rev ? q.pad[i_cmd1][31:8] - ssp_pkg::STEP_BYTE
                                        : q.pad[i_cmd1][31:8] + ssp_pkg::STEP_BYTE;
          end
        end
        if (chain_op) begin
          n.pad[i_car][31:8] = (q.op == ssp_pkg::OP_CHAIN4)
                               ? cur_car + ssp_pkg::STEP_CHAIN4
                               : cur_car + ssp_pkg::STEP_CHAIN;
          n.level  = ssp_pkg::LVL_CAR_ADV_2;
          n.state  = ssp_pkg::st_mem;
          word_sel = ssp_pkg::WI_CMD1;
        end else if (q.op == ssp_pkg::OP_SCRATCH) begin
          n.level  = ssp_pkg::LVL_SP_WRITE;
          n.state  = ssp_pkg::st_done;
          word_sel = ssp_pkg::WI_ASM;
        end else if (byte_op) begin
          n.level  = (q.op == ssp_pkg::OP_PART)
                     ? (q.wr ? ssp_pkg::LVL_PART_OUT : ssp_pkg::LVL_PART_IN)
                     : (q.wr ? ssp_pkg::LVL_MM_READ : ssp_pkg::LVL_MM_WRITE);
          n.load   = (q.op == ssp_pkg::OP_FULL) && q.wr;
          n.state  = ssp_pkg::st_mem;
          word_sel = ssp_pkg::WI_CMD1;
        end else begin
          n.state = ssp_pkg::st_idle;
        end
      end
      ssp_pkg::st_mem: begin
        n.state  = ssp_pkg::st_done;
        word_sel = ssp_pkg::WI_ASM;
        if (chain_op) begin
          n.level  = ssp_pkg::LVL_TIC_1;
          word_sel = ssp_pkg::WI_CAR;
        end else if (cur_cnt == 16'h0000) begin
          n.level = ssp_pkg::LVL_TERM_1;
        end else if (q.op == ssp_pkg::OP_FULL) begin
          n.level = ssp_pkg::LVL_MR_TO_MM;
          n.wback = 1'b1;
        end else begin
          n.level = ssp_pkg::LVL_SP_WRITE;
        end
      end
      ssp_pkg::st_done: begin
        n.state = ssp_pkg::st_idle;
        n.level = ssp_pkg::LVL_NONE;
      end
      default: begin
        n.state = ssp_pkg::st_idle;
      end
    endcase

    // entering service: the first level is chosen directly
    if ((q.state == ssp_pkg::st_idle) && (n.state == ssp_pkg::st_first)) begin
      n.level = first_level;
      if ((n.op == ssp_pkg::OP_CHAIN) || (n.op == ssp_pkg::OP_CHAIN4)) begin
        n.level  = ssp_pkg::LVL_CAR_ADV_1;
        word_sel = ssp_pkg::WI_CAR;
      end
    end
    n.spaddr = next_spaddr;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q       <= '0;
      q.state <= ssp_pkg::st_idle;
    end else begin
      q <= n;
    end
  end

  assign prdata_o                       = q.prdata;
  assign pready_o                       = q.pready;
  assign pslverr_o                      = q.pslverr;
  assign scratch_addr_o                 = q.spaddr;
  assign status_level_o                 = q.level;
  assign command_code_o                 = q.cmd;
  assign selector_mode_level_o          = q.mode;
  assign memory_register_load_command_o = q.load;
  assign memory_writeback_command_o     = q.wback;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb access not answered next cycle");
  a_count_step: assert property (q.state == ssp_pkg::st_first && byte_op
    |=> cur_cnt == $past(cur_cnt) - 16'h0001) else $error("byte count not decremented");
  a_chain_step: assert property (q.state == ssp_pkg::st_first && q.op == ssp_pkg::OP_CHAIN
    |=> cur_car == $past(cur_car) + 24'h000008) else $error("address word step wrong");
  a_full_step: assert property (q.state == ssp_pkg::st_first && q.op == ssp_pkg::OP_FULL && !q.rev
    |=> q.pad[i_cmd1][31:8] == $past(q.pad[i_cmd1][31:8]) + 24'h000004)
    else $error("full word address step wrong");
  a_mode_bit: assert property (q.mode |-> scratch_addr_o[4])
    else $error("address bit 4 missing in selector mode");
  a_first_sel: assert property (q.state == ssp_pkg::st_first && !chain_op
    |-> scratch_addr_o[2:0] == 3'h3) else $error("first level not on command two");
  a_load_pulse: assert property (memory_register_load_command_o
    |-> status_level_o == 6'h1C ##1 !memory_register_load_command_o)
    else $error("register load not a read pulse");
  a_level_seq: assert property (q.state == ssp_pkg::st_first |=> q.state != ssp_pkg::st_first
    ##[1:2] q.state == ssp_pkg::st_idle) else $error("service sequence too long");
  a_dchain_hold: assert property (q.state == ssp_pkg::st_first && q.dchain
    |=> $stable(command_code_o)) else $error("command code taken while chaining");

endmodule

`default_nettype wire

// file: ssp_far_model.sv
// far side model: watches scratch pad address, levels and memory commands
`timescale 1ns/100ps
`default_nettype none

module ssp_far_model (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        clr_i,
  input  wire logic [6:0]  scratch_addr_i,
  input  wire logic [5:0]  status_level_i,
  input  wire logic        load_i,
  input  wire logic        wb_i,
  output logic      [17:0] seq_o,
  output logic      [3:0]  hi_o,
  output logic             bad_o,
  output logic      [3:0]  loads_o,
  output logic      [3:0]  wbs_o
);
  // ==========================================================
  // level history and command tally
  // repeated levels collapse and level 00 is skipped, so only changes to a nonzero level are kept
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i || clr_i) begin
      seq_o   <= 18'h00000;
      hi_o    <= 4'h0;
      bad_o   <= 1'b0;
      loads_o <= 4'h0;
      wbs_o   <= 4'h0;
    end else begin
      if (status_level_i != 6'h00 && status_level_i != seq_o[5:0]) begin
        seq_o <= {seq_o[11:0], status_level_i};
      end
      if (status_level_i != 6'h00) begin
        hi_o <= scratch_addr_i[6:3];
        if (scratch_addr_i[2:0] < 3'h2 || scratch_addr_i[2:0] > 3'h5) begin
          bad_o <= 1'b1;
        end
      end
      loads_o <= loads_o + {3'h0, load_i};
      wbs_o   <= wbs_o + {3'h0, wb_i};
    end
  end
endmodule

`default_nettype wire

// file: selector_scratch_pad_addressing_tb.sv
// self-checking bench for the selector scratch pad block
`timescale 1ns/100ps
`default_nettype none

module selector_scratch_pad_addressing_tb;
  // ==========================================================
  // signals
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic        clr       = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [6:0]  scratch_addr_o;
  logic [5:0]  status_level_o;
  logic [7:0]  command_code_o;
  logic        mode_o;
  logic        load_o;
  logic        wb_o;
  logic [17:0] seq;
  logic [3:0]  hi;
  logic        bad;
  logic [3:0]  nld;
  logic [3:0]  nwb;
  logic [7:0]  code_exp;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  ssp_scratch_pad DUT (
    .clk_sys_i                      (clk_sys_i),
    .nrst_i                         (nrst_i),
    .psel_i                         (psel_i),
    .penable_i                      (penable_i),
    .pwrite_i                       (pwrite_i),
    .paddr_i                        (paddr_i),
    .pwdata_i                       (pwdata_i),
    .prdata_o                       (prdata_o),
    .pready_o                       (pready_o),
    .pslverr_o                      (pslverr_o),
    .scratch_addr_o                 (scratch_addr_o),
    .status_level_o                 (status_level_o),
    .command_code_o                 (command_code_o),
    .selector_mode_level_o          (mode_o),
    .memory_register_load_command_o (load_o),
    .memory_writeback_command_o     (wb_o)
  );

  ssp_far_model FAR (
    .clk_sys_i      (clk_sys_i),
    .nrst_i         (nrst_i),
    .clr_i          (clr),
    .scratch_addr_i (scratch_addr_o),
    .status_level_i (status_level_o),
    .load_i         (load_o),
    .wb_i           (wb_o),
    .seq_o          (seq),
    .hi_o           (hi),
    .bad_o          (bad),
    .loads_o        (nld),
    .wbs_o          (nwb)
  );

  // ==========================================================
  // verdict, timeout and compare
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a run of this length means the sequencer or the bus hung
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // ends on pready; only the bench timeout ends a hung wait
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  function automatic logic [11:0] pa(input logic [2:0] c, input logic [1:0] w);
    return {5'h00, c, w, 2'b00};
  endfunction

  // ==========================================================
  // one service operation on a preloaded channel
  task automatic run_op(input logic [2:0] ch, input logic [2:0] op, input logic rev,
                        input logic wd, input logic [1:0] bs, input logic dch,
                        input logic [15:0] cnt, input logic [17:0] lv,
                        input logic [3:0] nl, input logic [3:0] nw);
    logic [31:0] q;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [31:0] channel_address_word;
    logic [31:0] step;
    c1   = {24'h000200, 5'h18, ch};
    c2   = {cnt, 16'h0005};
    channel_address_word  = {24'h000100, 5'h02, ch};
    step = (op == 3'h0) ? 32'h400 : (op == 3'h1) ? 32'h100 : 32'h0;
    wr(pa(ch, 2'h0), channel_address_word);
    wr(pa(ch, 2'h1), c1);
    wr(pa(ch, 2'h2), c2);
    wr(pa(ch, 2'h3), 32'h0);
    @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    wr(ssp_pkg::ADDR_CTRL, {1'b1, 11'h0, 8'h5A, bs, 1'b1, dch, wd, rev, op, ch});
    do begin
      rd(ssp_pkg::ADDR_STAT, q);
    end while (q[0] !== 1'b0);
    chk({14'h0, seq}, {14'h0, lv});
    rd(pa(ch, 2'h1), q);
    chk(q, rev ? c1 - step : c1 + step);
    rd(pa(ch, 2'h2), q);
    chk(q, (op <= 3'h2) ? c2 - 32'h10000 : c2);
    rd(pa(ch, 2'h0), q);
    chk(q, channel_address_word + ((op == 3'h3) ? 32'h800 : (op == 3'h4) ? 32'h1000 : 32'h0));
    rd(pa(ch, 2'h3), q);
    chk(q, (op <= 3'h2) ? (32'h5A << (bs * 8)) : 32'h0);
    chk({28'h0, hi}, {28'h0, ssp_pkg::CHAN_CODE[ch]});
    chk({31'h0, bad}, 32'h0);
    chk({24'h0, nld, nwb}, {24'h0, nl, nw});
    if (!dch) begin
      code_exp = c1[7:0];
    end
    chk({24'h0, command_code_o}, {24'h0, code_exp});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (3) @(posedge clk_sys_i);
    chk({25'h0, pready_o, status_level_o}, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      rd(12'(i * 4), q);
      chk(q, 32'h0);
      wr(12'(i * 4), {8'hA5, 8'(i), 8'h3C, 8'(i)});
    end
    for (int i = 0; i < 24; i++) begin
      rd(12'(i * 4), q);
      chk(q, {8'hA5, 8'(i), 8'h3C, 8'(i)});
    end
    apb(1'b0, 12'h060, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1'b1, ssp_pkg::ADDR_STAT, 32'hFFFFFFFF, q, e);
    chk({31'h0, e}, 32'h1);
    wr(ssp_pkg::ADDR_CTRL, 32'h80000000);
    rd(ssp_pkg::ADDR_STAT, q);
    chk({31'h0, q[0]}, 32'h0);
    chk({28'h0, scratch_addr_o[6:3]}, 32'h0);
    code_exp = 8'h00;
    run_op(3'h0, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0, 16'h0010, {6'h10, 6'h38, 6'h0F}, 4'h0, 4'h1);
    run_op(3'h5, 3'h0, 1'b1, 1'b1, 2'h3, 1'b0, 16'h0010, {6'h30, 6'h1C, 6'h0F}, 4'h1, 4'h1);
    run_op(3'h2, 3'h1, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0003, {6'h12, 6'h08, 6'h0D}, 4'h0, 4'h0);
    run_op(3'h1, 3'h1, 1'b1, 1'b1, 2'h0, 1'b0, 16'h0001, {6'h31, 6'h09, 6'h0E}, 4'h0, 4'h0);
    run_op(3'h3, 3'h1, 1'b1, 1'b0, 2'h2, 1'b1, 16'h0002, {6'h11, 6'h08, 6'h0D}, 4'h0, 4'h0);
    run_op(3'h4, 3'h2, 1'b0, 1'b0, 2'h2, 1'b0, 16'h0020, {6'h00, 6'h10, 6'h0D}, 4'h0, 4'h0);
    run_op(3'h4, 3'h3, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0020, {6'h3B, 6'h3C, 6'h39}, 4'h0, 4'h0);
    run_op(3'h1, 3'h4, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0020, {6'h3B, 6'h3C, 6'h39}, 4'h0, 4'h0);
    wr(ssp_pkg::ADDR_CTRL, 32'h00000200);
    repeat (3) @(posedge clk_sys_i);
    chk({30'h0, mode_o, scratch_addr_o[4]}, 32'h3);
    wr(ssp_pkg::ADDR_CTRL, 32'h00000000);
    repeat (3) @(posedge clk_sys_i);
    chk({27'h0, mode_o, scratch_addr_o[6:3]}, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
